// File: hw/ams_defs.vh
// shared constants for the asynchronous memory strobe sequencer
`ifndef AMS_DEFS_VH
`define AMS_DEFS_VH

// reference clock period in ns (cpu clock)
`define AMS_REF_CLK_NS 5

// interface input clock source select codes
`define AMS_SRC_PIN 2'h0
`define AMS_SRC_CPU4 2'h1
`define AMS_SRC_CPU6 2'h2

// half periods of the internal sources, in reference cycles
`define AMS_CPU4_HALF 3'h2
`define AMS_CPU6_HALF 3'h3

// divided output clock select codes (N = 1, 2, 4)
`define AMS_DIV1 2'h0
`define AMS_DIV2 2'h1
`define AMS_DIV4 2'h2

// rising edges of the full clock between toggles of the divided clock
`define AMS_DIV2_RISES 1'h0
`define AMS_DIV4_RISES 1'h1

// strobe counter value at the ready sample point, two cycles before the
// programmed end, and the two-cycle tail once ready is seen high again
`define AMS_RDY_SAMPLE_LEFT 8'h03
`define AMS_RDY_TAIL_LEFT 8'h02

// sequencer states
`define AMS_ST_IDLE 3'h0
`define AMS_ST_SETUP 3'h1
`define AMS_ST_STROBE 3'h2
`define AMS_ST_WAIT 3'h3
`define AMS_ST_HOLD 3'h4

`endif

// File: hw/ams_sync.v
// two flip-flop synchroniser for pin inputs
module ams_sync #(
	parameter WIDTH = 1
) (
	input wire ref_clk_i,
	input wire rst_n_i,
	input wire [WIDTH-1:0] async_i,
	output wire [WIDTH-1:0] sync_o
);
	reg [WIDTH-1:0] meta_q;
	reg [WIDTH-1:0] sync_q;

	// meta_q feeds sync_q only
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_q <= {WIDTH{1'b0}};
			sync_q <= {WIDTH{1'b0}};
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end

	assign sync_o = sync_q;
endmodule // ams_sync

// File: hw/ams_clk_gen.v
// interface input clock selection and memory clock outputs
`include "ams_defs.vh"
module ams_clk_gen (
	input wire ref_clk_i,
	input wire rst_n_i,
	input wire [1:0] src_sel_i,
	input wire [1:0] div_sel_i,
	input wire pin_lvl_i,
	output wire full_o,
	output wire divided_o,
	output wire rise_tick_o
);
	reg [2:0] half_q;
	reg [2:0] half_d;
	reg full_q;
	reg full_d;
	reg div_q;
	reg div_d;
	reg rise_cnt_q;
	reg rise_cnt_d;
	reg tick_q;
	wire [2:0] half_lim;
	wire rise;
	wire rise_lim;

	// code 3 is unused and behaves as cpu/4
	assign half_lim = (src_sel_i == `AMS_SRC_CPU6) ? `AMS_CPU6_HALF :
		`AMS_CPU4_HALF;
	assign rise = full_d & ~full_q;
	assign rise_lim = (div_sel_i == `AMS_DIV4) ? `AMS_DIV4_RISES :
		`AMS_DIV2_RISES;

	always @* begin
		full_d = full_q;
		half_d = half_q;
		if (src_sel_i == `AMS_SRC_PIN) begin
			full_d = pin_lvl_i; // (RULE12)
			half_d = 3'h0;
		end else if (half_q >= half_lim - 3'h1) begin
			full_d = ~full_q; // (RULE12)
			half_d = 3'h0;
		end else begin
			half_d = half_q + 3'h1;
		end
	end

	// divided clock moves on full-clock rises so both stay edge aligned
	always @* begin
		div_d = div_q;
		rise_cnt_d = rise_cnt_q;
		if (div_sel_i == `AMS_DIV1) begin
			div_d = full_d; // (RULE13)
			rise_cnt_d = 1'b0;
		end else if (rise) begin
			if (rise_cnt_q == rise_lim) begin
				div_d = ~div_q; // (RULE13)
				rise_cnt_d = 1'b0;
			end else begin
				rise_cnt_d = rise_cnt_q + 1'b1;
			end
		end
	end

	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			half_q <= 3'h0;
			full_q <= 1'b0;
			div_q <= 1'b0;
			rise_cnt_q <= 1'b0;
			tick_q <= 1'b0;
		end else begin
			half_q <= half_d;
			full_q <= full_d;
			div_q <= div_d;
			rise_cnt_q <= rise_cnt_d;
			tick_q <= rise; // (RULE14)
		end
	end

	assign full_o = full_q;
	assign divided_o = div_q;
	assign rise_tick_o = tick_q;
endmodule // ams_clk_gen

// File: hw/ams_async_ctrl.v
// asynchronous memory access sequencer with ready stretch and clocks
// Functional notes
// (RULE1) ready input passes an internal synchroniser before any use
// (RULE2) ready sampled only two cycles before programmed strobe end
// (RULE3) while sampled ready is low, strobe extends one cycle at a time
// (RULE4) after low ready, strobe ends two cycles after ready seen high
// (RULE5) memory holds each ready level about two interface clock periods
// (RULE6) access is setup, strobe, hold; counts per space, read and write
// (RULE7) reads: selects valid setup cycles before and hold cycles after strobe
// (RULE8) writes: selects and data valid setup before, hold after strobe
// (RULE9) wide port selects: chip select, eight byte enables, address, enable
// (RULE10) narrow port selects: chip select, two byte enables, address, enable
// (RULE11) write data bus belongs to the select group during writes
// (RULE12) interface clock from pin, cpu clock over four or over six
// (RULE13) divided clock period is N input periods, N of 1, 2, 4
// (RULE14) strobe and ready timing step on the full memory clock
// (RULE15) shared pins act as output enable, read and write strobe
// (RULE16) strobe low for programmed count plus extension, high when idle
// (RULE17) output enable low only in reads, high in writes and idle
`include "ams_defs.vh"
module ams_async_ctrl #(
	parameter DATA_W = 64,
	parameter BE_W = 8,
	parameter ADDR_W = 20,
	parameter NUM_CS = 4,
	parameter CS_W = 2,
	parameter SETUP_W = 4,
	parameter STROBE_W = 6,
	parameter HOLD_W = 3
) (
	input wire ref_clk_i,
	input wire rst_n_i,
	input wire [1:0] clk_src_sel_i,
	input wire [1:0] clk_div_sel_i,
	input wire ext_mem_clk_in_i,
	output wire mem_clk_out_full_o,
	output wire mem_clk_out_divided_o,
	input wire [NUM_CS*SETUP_W-1:0] read_setup_cycles_i,
	input wire [NUM_CS*STROBE_W-1:0] read_strobe_cycles_i,
	input wire [NUM_CS*HOLD_W-1:0] read_hold_cycles_i,
	input wire [NUM_CS*SETUP_W-1:0] write_setup_cycles_i,
	input wire [NUM_CS*STROBE_W-1:0] write_strobe_cycles_i,
	input wire [NUM_CS*HOLD_W-1:0] write_hold_cycles_i,
	input wire req_valid_i,
	output wire req_ready_o,
	input wire req_write_i,
	input wire [CS_W-1:0] req_cs_i,
	input wire [ADDR_W-1:0] req_addr_i,
	input wire [BE_W-1:0] req_be_i,
	input wire [DATA_W-1:0] req_wdata_i,
	output wire rd_valid_o,
	output wire [DATA_W-1:0] rd_data_o,
	output wire busy_o,
	output wire ready_wait_o,
	input wire async_ready_in_i,
	output wire [NUM_CS-1:0] chip_select_n_o,
	output wire [BE_W-1:0] byte_enable_n_o,
	output wire [ADDR_W-1:0] ext_addr_o,
	output wire async_output_enable_n_o,
	output wire async_read_strobe_n_o,
	output wire async_write_strobe_n_o,
	input wire [DATA_W-1:0] ext_data_i,
	output wire [DATA_W-1:0] ext_data_o,
	output wire ext_data_oe_o
);
	// counters are eight bits; phase count widths must stay below that
	localparam CNT_W = 8;

	reg [2:0] state_q;
	reg [2:0] state_d;
	reg [CNT_W-1:0] cnt_q;
	reg [CNT_W-1:0] cnt_d;
	reg wr_q;
	reg wr_d;
	reg [CS_W-1:0] cs_q;
	reg [CS_W-1:0] cs_d;
	reg [NUM_CS-1:0] cs_n_q;
	reg [NUM_CS-1:0] cs_n_d;
	reg [BE_W-1:0] be_n_q;
	reg [BE_W-1:0] be_n_d;
	reg [ADDR_W-1:0] addr_q;
	reg [ADDR_W-1:0] addr_d;
	reg oe_n_q;
	reg oe_n_d;
	reg re_n_q;
	reg re_n_d;
	reg we_n_q;
	reg we_n_d;
	reg [DATA_W-1:0] wdata_q;
	reg [DATA_W-1:0] wdata_d;
	reg data_oe_q;
	reg data_oe_d;
	reg [DATA_W-1:0] rdata_q;
	reg [DATA_W-1:0] rdata_d;
	reg rd_valid_q;
	reg rd_valid_d;

	wire tick;
	wire rdy_s;
	wire pin_clk_s;
	wire [DATA_W-1:0] data_s;
	wire take;
	wire [CNT_W-1:0] setup_take;
	wire [CNT_W-1:0] strobe_cur;
	wire [CNT_W-1:0] hold_cur;
	wire [NUM_CS-1:0] cs_onehot;

	function [CNT_W-1:0] ams_min1;
		input [CNT_W-1:0] v;
		begin
			ams_min1 = (v == {CNT_W{1'b0}}) ? {{(CNT_W-1){1'b0}}, 1'b1} : v;
		end
	endfunction

	ams_sync #(
		.WIDTH(1)
	) u_rdy_sync (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.async_i(async_ready_in_i), // (RULE1) (RULE5)
		.sync_o(rdy_s)
	);

	ams_sync #(
		.WIDTH(1)
	) u_clk_sync (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.async_i(ext_mem_clk_in_i),
		.sync_o(pin_clk_s)
	);

	// read data comes from the pins and is resynchronised like the ready and pin clock inputs
	ams_sync #(
		.WIDTH(DATA_W)
	) u_data_sync (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.async_i(ext_data_i),
		.sync_o(data_s)
	);

	ams_clk_gen u_clk_gen (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.src_sel_i(clk_src_sel_i),
		.div_sel_i(clk_div_sel_i),
		.pin_lvl_i(pin_clk_s),
		.full_o(mem_clk_out_full_o),
		.divided_o(mem_clk_out_divided_o),
		.rise_tick_o(tick)
	);

	// per-space count lookup (RULE6)
	assign setup_take = req_write_i ?
		{{(CNT_W-SETUP_W){1'b0}},
		write_setup_cycles_i[req_cs_i*SETUP_W +: SETUP_W]} :
		{{(CNT_W-SETUP_W){1'b0}},
		read_setup_cycles_i[req_cs_i*SETUP_W +: SETUP_W]};
	assign strobe_cur = wr_q ?
		{{(CNT_W-STROBE_W){1'b0}},
		write_strobe_cycles_i[cs_q*STROBE_W +: STROBE_W]} :
		{{(CNT_W-STROBE_W){1'b0}},
		read_strobe_cycles_i[cs_q*STROBE_W +: STROBE_W]};
	assign hold_cur = wr_q ?
		{{(CNT_W-HOLD_W){1'b0}},
		write_hold_cycles_i[cs_q*HOLD_W +: HOLD_W]} :
		{{(CNT_W-HOLD_W){1'b0}},
		read_hold_cycles_i[cs_q*HOLD_W +: HOLD_W]};

	genvar g;
	generate
		for (g = 0; g < NUM_CS; g = g + 1) begin : g_cs
			assign cs_onehot[g] = (req_cs_i == g);
		end
	endgenerate

	// requests are only taken on a full-clock rise so phases line up
	assign take = (state_q == `AMS_ST_IDLE) & tick & req_valid_i; // (RULE14)

	always @* begin
		state_d = state_q;
		cnt_d = cnt_q;
		wr_d = wr_q;
		cs_d = cs_q;
		cs_n_d = cs_n_q;
		be_n_d = be_n_q;
		addr_d = addr_q;
		oe_n_d = oe_n_q;
		re_n_d = re_n_q;
		we_n_d = we_n_q;
		wdata_d = wdata_q;
		data_oe_d = data_oe_q;
		rdata_d = rdata_q;
		rd_valid_d = 1'b0;
		if (tick) begin
			case (state_q)
				`AMS_ST_IDLE: begin
					if (req_valid_i) begin
						state_d = `AMS_ST_SETUP; // (RULE6)
						cnt_d = ams_min1(setup_take);
						wr_d = req_write_i;
						cs_d = req_cs_i;
						cs_n_d = ~cs_onehot; // (RULE9) (RULE10)
						be_n_d = ~req_be_i;
						addr_d = req_addr_i;
						oe_n_d = req_write_i; // (RULE17)
						wdata_d = req_wdata_i; // (RULE11)
						data_oe_d = req_write_i; // (RULE8) (RULE11)
					end
				end
				`AMS_ST_SETUP: begin
					if (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1}) begin
						state_d = `AMS_ST_STROBE;
						cnt_d = ams_min1(strobe_cur);
						re_n_d = wr_q; // (RULE7) (RULE15)
						we_n_d = ~wr_q; // (RULE8) (RULE15)
					end else begin
						cnt_d = cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
					end
				end
				`AMS_ST_STROBE: begin
					if (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1}) begin
						re_n_d = 1'b1; // (RULE16)
						we_n_d = 1'b1; // (RULE16)
						if (!wr_q) begin
							rdata_d = data_s;
							rd_valid_d = 1'b1;
						end
						cnt_d = hold_cur;
						if (hold_cur == {CNT_W{1'b0}}) begin
							state_d = `AMS_ST_IDLE;
							cs_n_d = {NUM_CS{1'b1}};
							be_n_d = {BE_W{1'b1}};
							oe_n_d = 1'b1;
							data_oe_d = 1'b0;
						end else begin
							state_d = `AMS_ST_HOLD; // (RULE7) (RULE8)
						end
					end else if (cnt_q == `AMS_RDY_SAMPLE_LEFT && !rdy_s) begin
						state_d = `AMS_ST_WAIT; // (RULE2) (RULE3)
					end else begin
						cnt_d = cnt_q - {{(CNT_W-1){1'b0}}, 1'b1}; // (RULE2)
					end
				end
				`AMS_ST_WAIT: begin
					if (rdy_s) begin
						state_d = `AMS_ST_STROBE; // (RULE4)
						cnt_d = `AMS_RDY_TAIL_LEFT;
					end
				end
				`AMS_ST_HOLD: begin
					if (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1}) begin
						state_d = `AMS_ST_IDLE;
						cs_n_d = {NUM_CS{1'b1}};
						be_n_d = {BE_W{1'b1}};
						oe_n_d = 1'b1; // (RULE17)
						data_oe_d = 1'b0;
					end else begin
						cnt_d = cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
					end
				end
				default: begin
					state_d = `AMS_ST_IDLE;
					cs_n_d = {NUM_CS{1'b1}};
					re_n_d = 1'b1;
					we_n_d = 1'b1;
					oe_n_d = 1'b1;
					data_oe_d = 1'b0;
				end
			endcase
		end
	end

	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= `AMS_ST_IDLE;
			cnt_q <= {CNT_W{1'b0}};
			wr_q <= 1'b0;
			cs_q <= {CS_W{1'b0}};
			cs_n_q <= {NUM_CS{1'b1}};
			be_n_q <= {BE_W{1'b1}};
			addr_q <= {ADDR_W{1'b0}};
			oe_n_q <= 1'b1;
			re_n_q <= 1'b1;
			we_n_q <= 1'b1;
			wdata_q <= {DATA_W{1'b0}};
			data_oe_q <= 1'b0;
			rdata_q <= {DATA_W{1'b0}};
			rd_valid_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			wr_q <= wr_d;
			cs_q <= cs_d;
			cs_n_q <= cs_n_d;
			be_n_q <= be_n_d;
			addr_q <= addr_d;
			oe_n_q <= oe_n_d;
			re_n_q <= re_n_d;
			we_n_q <= we_n_d;
			wdata_q <= wdata_d;
			data_oe_q <= data_oe_d;
			rdata_q <= rdata_d;
			rd_valid_q <= rd_valid_d;
		end
	end

	assign req_ready_o = take;
	assign rd_valid_o = rd_valid_q;
	assign rd_data_o = rdata_q;
	assign busy_o = (state_q != `AMS_ST_IDLE);
	assign ready_wait_o = (state_q == `AMS_ST_WAIT);
	assign chip_select_n_o = cs_n_q;
	assign byte_enable_n_o = be_n_q;
	assign ext_addr_o = addr_q;
	assign async_output_enable_n_o = oe_n_q;
	assign async_read_strobe_n_o = re_n_q;
	assign async_write_strobe_n_o = we_n_q;
	assign ext_data_o = wdata_q;
	assign ext_data_oe_o = data_oe_q;
endmodule // ams_async_ctrl

// File: tb/ams_async_ctrl_assertions.sv
// port checks for the asynchronous memory sequencer
module ams_chk #(
	parameter DATA_W = 64,
	parameter ADDR_W = 20,
	parameter NUM_CS = 4
) (
	input wire ref_clk_i,
	input wire rst_n_i,
	input wire [1:0] clk_src_sel_i,
	input wire [1:0] clk_div_sel_i,
	input wire mem_clk_out_full_o,
	input wire mem_clk_out_divided_o,
	input wire busy_o,
	input wire ready_wait_o,
	input wire rd_valid_o,
	input wire [NUM_CS-1:0] chip_select_n_o,
	input wire [ADDR_W-1:0] ext_addr_o,
	input wire async_output_enable_n_o,
	input wire async_read_strobe_n_o,
	input wire async_write_strobe_n_o,
	input wire [DATA_W-1:0] ext_data_o,
	input wire ext_data_oe_o
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_rd_end;
		$rose(async_read_strobe_n_o);
	endsequence
	sequence s_wr_begin;
		$fell(async_write_strobe_n_o);
	endsequence
	a_idle_quiet: assert property (
		!busy_o [*2] |-> async_read_strobe_n_o && async_write_strobe_n_o
			&& async_output_enable_n_o && &chip_select_n_o)
		else $error("strobe or select active while idle");
	a_oe_in_write: assert property (
		!async_write_strobe_n_o || ext_data_oe_o |-> async_output_enable_n_o)
		else $error("output enable low in a write");
	a_read_strobe: assert property (
		!async_read_strobe_n_o |-> async_write_strobe_n_o
			&& !async_output_enable_n_o && !(&chip_select_n_o))
		else $error("read strobe without its selects");
	a_rd_setup: assert property (
		$fell(async_read_strobe_n_o) |-> $stable(ext_addr_o)
			&& $stable(chip_select_n_o))
		else $error("selects moved as read strobe fell");
	a_wr_setup: assert property (
		s_wr_begin |-> ext_data_oe_o && $stable(ext_data_o)
			&& $stable(ext_addr_o))
		else $error("write data not set up");
	a_rd_answer: assert property (
		s_rd_end |-> ##[0:1] rd_valid_o)
		else $error("no read data after strobe");
	a_wait_held: assert property (
		ready_wait_o |-> !async_read_strobe_n_o || !async_write_strobe_n_o)
		else $error("stretch without strobe");
	a_cpu4_period: assert property (
		$rose(mem_clk_out_full_o) && clk_src_sel_i == 2'h1
			&& $past(clk_src_sel_i, 8) == 2'h1 |-> ##4 $rose(mem_clk_out_full_o))
		else $error("full clock period wrong");
	a_cpu6_period: assert property (
		$rose(mem_clk_out_full_o) && clk_src_sel_i == 2'h2
			&& $past(clk_src_sel_i, 8) == 2'h2 |-> ##6 $rose(mem_clk_out_full_o))
		else $error("cpu six full clock period wrong");
	a_div2_period: assert property (
		$rose(mem_clk_out_divided_o) && clk_div_sel_i == 2'h1
			&& $past(clk_div_sel_i, 12) == 2'h1 && clk_src_sel_i == 2'h2
			&& $past(clk_src_sel_i, 12) == 2'h2
			|-> ##12 $rose(mem_clk_out_divided_o))
		else $error("half rate divided clock period wrong");
	a_div4_period: assert property (
		$rose(mem_clk_out_divided_o) && clk_div_sel_i == 2'h2
			&& $past(clk_div_sel_i, 16) == 2'h2 && clk_src_sel_i == 2'h1
			&& $past(clk_src_sel_i, 16) == 2'h1
			|-> ##16 $rose(mem_clk_out_divided_o))
		else $error("divided clock period wrong");
endmodule // ams_chk
bind ams_async_ctrl ams_chk #(.DATA_W(DATA_W), .ADDR_W(ADDR_W),
	.NUM_CS(NUM_CS)) i_ams_chk (.*);

// File: tb/ams_mem_model.sv
// behavioural asynchronous static memory with a ready stretch
module ams_mem_model (
	input wire [3:0] cs_n_i,
	input wire [7:0] be_n_i,
	input wire [19:0] addr_i,
	input wire oe_n_i,
	input wire re_n_i,
	input wire we_n_i,
	input wire [63:0] wdata_i,
	input int stall_i,
	output logic [63:0] rdata_o,
	output logic rdy_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [63:0] mem [0:63];
	initial begin
		rdy_o = 1;
		rdata_o = 64'h0;
		for (int i = 0; i < 64; i++) mem[i] = 64'h0;
	end
	function int key();
		for (int i = 0; i < 4; i++) if (!cs_n_i[i]) return i * 16 + addr_i[3:0];
		return 0;
	endfunction
	// low level kept a whole stall, never under two memory clocks
	always @(negedge re_n_i) if (stall_i > 0) begin
		#1 rdy_o = 0;
		#(stall_i * 5) rdy_o = 1;
	end
	// released bus shows the inverse of the last word, so stale reads fail
	always @(cs_n_i, oe_n_i, addr_i)
		rdata_o = (!oe_n_i && !(&cs_n_i)) ? mem[key()] : ~rdata_o;
	always @(posedge we_n_i) if (!(&cs_n_i))
		for (int i = 0; i < 8; i++)
			if (!be_n_i[i]) mem[key()][8*i+:8] = wdata_i[8*i+:8];
endmodule // ams_mem_model

// File: tb/ams_async_ctrl_test.sv
// self-checking bench for the asynchronous memory sequencer
module ams_async_ctrl_test;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct {int su; int sw; int ho; bit win; logic [63:0] d;} ams_note_t;
	logic ref_clk_i = 0, rst_n_i = 0, ext_mem_clk_in_i = 0;
	logic [1:0] clk_src_sel_i = 2'h1, clk_div_sel_i = 2'h2, req_cs_i = 2'h0;
	logic [15:0] read_setup_cycles_i, write_setup_cycles_i;
	logic [23:0] read_strobe_cycles_i, write_strobe_cycles_i;
	logic [11:0] read_hold_cycles_i, write_hold_cycles_i;
	logic req_valid_i = 0, req_write_i = 0;
	logic [19:0] req_addr_i = 20'h0;
	logic [7:0] req_be_i = 8'h0;
	logic [63:0] req_wdata_i = 64'h0;
	wire req_ready_o, rd_valid_o, busy_o, ready_wait_o, ext_data_oe_o;
	wire async_output_enable_n_o, async_read_strobe_n_o, async_write_strobe_n_o;
	wire mem_clk_out_full_o, mem_clk_out_divided_o, async_ready_in_i;
	wire [63:0] rd_data_o, ext_data_o, ext_data_i;
	wire [3:0] chip_select_n_o;
	wire [7:0] byte_enable_n_o;
	wire [19:0] ext_addr_o;
	int rs[4] = '{1, 2, 3, 4}, rt[4] = '{3, 4, 5, 6}, rh[4] = '{0, 1, 2, 3};
	int ws[4] = '{4, 3, 2, 1}, wt[4] = '{2, 3, 4, 5}, wh[4] = '{1, 2, 3, 4};
	int e = 4, stall = 0, errors = 0, checks = 0, n, cyc = 0;
	int t_cs, t_sf, t_sr, t_ry;
	int seed = 32'h4462b485;
	ams_note_t q[$], cur;
	logic [63:0] sh [0:63];
	logic s_q = 1, c_q = 1, r_q = 1, seen = 0;
	wire s = async_read_strobe_n_o & async_write_strobe_n_o;
	ams_async_ctrl i_ams_async_ctrl (.*);
	ams_mem_model i_ams_mem_model (.cs_n_i(chip_select_n_o),
		.be_n_i(byte_enable_n_o), .addr_i(ext_addr_o),
		.oe_n_i(async_output_enable_n_o), .re_n_i(async_read_strobe_n_o),
		.we_n_i(async_write_strobe_n_o), .wdata_i(ext_data_o),
		.stall_i(stall), .rdata_o(ext_data_i), .rdy_o(async_ready_in_i));
	always #2.5 ref_clk_i = ~ref_clk_i;
	// pin clock slower than a quarter of the cpu clock, E of ten cycles
	always #25 ext_mem_clk_in_i = ~ext_mem_clk_in_i;
	task chk(input string nm, input logic [63:0] x, input logic [63:0] y);
		checks++;
		if (x !== y) begin
			errors++;
			$display("ERROR %s expected %0h seen %0h", nm, x, y);
		end
	endtask
	task tally_and_finish();
		if (errors == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task acc(input bit w, input int c, input int a, input int st);
		int k;
		logic r;
		logic [7:0] b;
		logic [63:0] d;
		b = $random(seed);
		d = {$random(seed), $random(seed)};
		k = c * 16 + a[3:0];
		q.push_back('{(w ? ws[c] : rs[c]) * e, (w ? wt[c] : rt[c]) * e,
			(w ? wh[c] : rh[c]) * e, st > 2 * e, sh[k]});
		if (w) for (int i = 0; i < 8; i++) if (b[i]) sh[k][8*i+:8] = d[8*i+:8];
		{req_valid_i, req_write_i, req_cs_i, req_addr_i} = {1'b1, w, c[1:0], a[19:0]};
		{req_be_i, req_wdata_i} = {b, d};
		r = 0;
		repeat (300) if (!r) begin
			@(negedge ref_clk_i) r = req_ready_o;
			@(posedge ref_clk_i) #1;
		end
		if (!r) errors++;
		stall = st;
		req_valid_i = 0;
		@(posedge ref_clk_i) #1;
	endtask
	always @(posedge ref_clk_i) if (rst_n_i) begin
		cyc++;
		if (c_q && !(&chip_select_n_o)) t_cs = cyc;
		if (s_q && !s) {t_sf, seen} = {cyc, 1'b0};
		if (ready_wait_o) seen = 1;
		if (!r_q && async_ready_in_i) t_ry = cyc;
		if (!s_q && s) begin
			t_sr = cyc;
			cur = q.pop_front();
			chk("setup", cur.su, t_sf - t_cs);
			chk("wait", cur.win, seen);
			if (cur.win) chk("stretch", 1, t_sr - t_ry >= 2 * e
				&& t_sr - t_ry <= 3 * e + 4);
			else chk("strobe", cur.sw, t_sr - t_sf);
		end
		if (!c_q && &chip_select_n_o) chk("hold", cur.ho, cyc - t_sr);
		if (rd_valid_o) chk("rdata", cur.d, rd_data_o);
		{s_q, c_q, r_q} = {s, &chip_select_n_o, async_ready_in_i};
	end
	initial begin
		for (int i = 0; i < 64; i++) sh[i] = 64'h0;
		for (int i = 0; i < 4; i++) begin
			read_setup_cycles_i[4*i+:4] = rs[i];
			write_setup_cycles_i[4*i+:4] = ws[i];
			read_strobe_cycles_i[6*i+:6] = rt[i];
			write_strobe_cycles_i[6*i+:6] = wt[i];
			read_hold_cycles_i[3*i+:3] = rh[i];
			write_hold_cycles_i[3*i+:3] = wh[i];
		end
		repeat (16) @(posedge ref_clk_i);
		#1 rst_n_i = 1;
		// sources cpu/4, cpu/6 and pin, switched only while idle
		for (int p = 0; p < 3; p++) begin
			// switch right after a divided rise so no period check straddles it
			@(posedge mem_clk_out_divided_o) #1;
			{clk_src_sel_i, clk_div_sel_i} = {2'((p + 1) % 3), 2'(2 - p)};
			e = p == 0 ? 4 : p == 1 ? 6 : 10;
			repeat (60) @(posedge ref_clk_i) #1;
			for (int i = 0; i < 8; i++) begin
				n = $random(seed);
				acc(1, i % 4, n, 0);
				acc(0, i % 4, n, i % 4 == 2 ? 5 * e : i % 4 == 3 ? 2 * e : 0);
			end
			repeat (300) @(posedge ref_clk_i) #1;
		end
		chk("pending", 0, q.size());
		tally_and_finish();
	end
	initial begin
		#250000;
		errors++;
		tally_and_finish();
	end
endmodule // ams_async_ctrl_test
